// ### core/two_level_interrupt_handler.sv
// two-level interrupt handler: pending flags, enables, priorities, arbitration
// ---------------------------------------------------------------
// Summary of operation
// - twelve sources, two priority levels
// - valid condition sets flag regardless of enable
// - enabled pending flag raises request, core vectors
// - routine ends with return, execution resumes
// - disabled source flag is ignored
// - per-source enables, gated by global enable bit
// - global enable clear blocks all sources
// - clear-enable race: single-cycle next may vector
// - software follows enable clear with two-byte opcode
// - some flags hardware-cleared, others by software
// - flag still set after return requests again
// - software writing one triggers interrupt
// - edge select and polarity per external input
// - edge-mode external flag cleared on vectoring
// - level-mode external flag follows input
// - level source holds input until recognised
// - external inputs sampled independent of crossbar
// - high preempts low, high never preempted
// - per-source priority bit, resets low
// - higher priority first, then fixed order
// - sampled each clock, five-clock fastest response
// - equal-or-lower request waits return plus one
// ---------------------------------------------------------------
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module two_level_interrupt_handler #(
    parameter int NUM_SRC = irq_pkg::NUM_SRC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // peripheral events, one-cycle pulses
    input wire logic [NUM_SRC-1:0] src_event_in,
    // external interrupt pins
    input wire logic ext_irq0_input_in,
    input wire logic ext_irq1_input_in,
    // in-service state
    output logic in_service_high_out,
    output logic in_service_low_out,
    // link to the core
    irq_link_if.handler link
);
    // decoder and register layout fixed at twelve sources
    if (NUM_SRC != irq_pkg::NUM_SRC) begin : g_bad_src_count
        $error("handler is built for exactly twelve sources");
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] primary_enable_reg;
    logic [7:0] extended_enable_reg;
    logic [7:0] primary_priority_reg;
    logic [7:0] extended_priority_reg;
    logic [7:0] ext_irq_pin_config_reg;
    logic [1:0] edge_sel_reg;
    logic [NUM_SRC-1:0] pending_reg;
    logic [NUM_SRC-1:0] pending_next;
    logic [1:0] ext_active_prev_reg;
    logic enable_grace_reg;
    logic ret_hold_reg;
    logic in_high_reg;
    logic in_low_reg;
    logic irq_req_reg;
    logic [irq_pkg::ID_W-1:0] irq_id_reg;
    logic [15:0] irq_vector_reg;
    logic [7:0] sfr_rdata_reg;

    logic [NUM_SRC-1:0] enable_vec;
    logic [NUM_SRC-1:0] priority_vec;
    logic [NUM_SRC-1:0] sw_set;
    logic [NUM_SRC-1:0] sw_clr;
    logic [NUM_SRC-1:0] hw_set;
    logic [NUM_SRC-1:0] hw_clr;
    logic [1:0] ext_active;
    logic [1:0] ext_pin;
    logic [1:0] ext_pol;
    logic [1:0] ext_flag_pos_hit;
    logic global_gate;
    logic [NUM_SRC-1:0] eligible;
    logic [NUM_SRC-1:0] cand_high;
    logic [NUM_SRC-1:0] cand_low;
    logic win_valid;
    logic win_high;
    logic [irq_pkg::ID_W-1:0] win_id;

    assign enable_vec = {extended_enable_reg[5:0], primary_enable_reg[5:0]};
    assign priority_vec = {extended_priority_reg[5:0], primary_priority_reg[5:0]};

    // ---------------------------------------------------------------
    // external inputs
    // ---------------------------------------------------------------
    // pins read only, never driven, so crossbar users are undisturbed
    assign ext_pin = {ext_irq1_input_in, ext_irq0_input_in};
    assign ext_pol = {ext_irq_pin_config_reg[irq_pkg::EXT1_POL_BIT],
                      ext_irq_pin_config_reg[irq_pkg::EXT0_POL_BIT]};
    assign ext_active = ~(ext_pin ^ ext_pol);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ext_active_prev_reg <= 2'h0;
        end else begin
            ext_active_prev_reg <= ext_active;
        end
    end

    // ---------------------------------------------------------------
    // pending flags
    // ---------------------------------------------------------------
    assign ext_flag_pos_hit = {link.sfr_wr && link.sfr_addr == irq_pkg::SFR_TIMER_CONTROL,
                               link.sfr_wr && link.sfr_addr == irq_pkg::SFR_TIMER_CONTROL};

    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        hw_set = src_event_in;
        hw_clr = '0;
        if (link.sfr_wr && link.sfr_addr == irq_pkg::SFR_PENDING_LO) begin
            sw_set[7:0] = link.sfr_wdata;
            sw_clr[7:0] = ~link.sfr_wdata;
        end
        if (link.sfr_wr && link.sfr_addr == irq_pkg::SFR_PENDING_HI) begin
            sw_set[11:8] = link.sfr_wdata[3:0];
            sw_clr[11:8] = ~link.sfr_wdata[3:0];
        end
        if (ext_flag_pos_hit[0]) begin
            sw_set[irq_pkg::EXT0_SRC] = link.sfr_wdata[irq_pkg::EXT0_FLAG_BIT];
            sw_clr[irq_pkg::EXT0_SRC] = ~link.sfr_wdata[irq_pkg::EXT0_FLAG_BIT];
            sw_set[irq_pkg::EXT1_SRC] = link.sfr_wdata[irq_pkg::EXT1_FLAG_BIT];
            sw_clr[irq_pkg::EXT1_SRC] = ~link.sfr_wdata[irq_pkg::EXT1_FLAG_BIT];
        end
        // edge mode: flag set on the inactive-to-active transition
        hw_set[irq_pkg::EXT0_SRC] = edge_sel_reg[0] && ext_active[0] && !ext_active_prev_reg[0];
        hw_set[irq_pkg::EXT1_SRC] = edge_sel_reg[1] && ext_active[1] && !ext_active_prev_reg[1];
        if (link.take) begin
            // fixed set of flags cleared on vectoring
            hw_clr[link.take_id] = irq_pkg::HW_CLEAR_MASK[link.take_id];
            // edge-mode external flags cleared on vectoring
            if (link.take_id == irq_pkg::ID_W'(irq_pkg::EXT0_SRC) && edge_sel_reg[0]) begin
                hw_clr[irq_pkg::EXT0_SRC] = 1'b1;
            end
            if (link.take_id == irq_pkg::ID_W'(irq_pkg::EXT1_SRC) && edge_sel_reg[1]) begin
                hw_clr[irq_pkg::EXT1_SRC] = 1'b1;
            end
        end
        // set wins over any clear in the same cycle
        pending_next = (pending_reg & ~sw_clr & ~hw_clr) | hw_set | sw_set;
        // level mode: flag mirrors the active level
        if (!edge_sel_reg[0]) begin
            pending_next[irq_pkg::EXT0_SRC] = ext_active[0];
        end
        if (!edge_sel_reg[1]) begin
            pending_next[irq_pkg::EXT1_SRC] = ext_active[1];
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pending_reg <= '0;
        end else begin
            pending_reg <= pending_next;
        end
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            primary_enable_reg <= irq_pkg::SFR_RESET;
            extended_enable_reg <= irq_pkg::SFR_RESET;
            primary_priority_reg <= irq_pkg::SFR_RESET;
            extended_priority_reg <= irq_pkg::SFR_RESET;
            ext_irq_pin_config_reg <= irq_pkg::SFR_RESET;
            edge_sel_reg <= 2'h0;
        end else if (link.sfr_wr) begin
            case (link.sfr_addr)
                irq_pkg::SFR_PRIMARY_ENABLE: primary_enable_reg <= link.sfr_wdata;
                irq_pkg::SFR_EXTENDED_ENABLE: extended_enable_reg <= link.sfr_wdata;
                irq_pkg::SFR_PRIMARY_PRIORITY: primary_priority_reg <= link.sfr_wdata;
                irq_pkg::SFR_EXTENDED_PRIORITY: extended_priority_reg <= link.sfr_wdata;
                irq_pkg::SFR_EXT_PIN_CONFIG: ext_irq_pin_config_reg <= link.sfr_wdata;
                irq_pkg::SFR_TIMER_CONTROL: begin
                    // edge select one means edge sensing
                    edge_sel_reg <= {link.sfr_wdata[irq_pkg::EXT1_EDGE_BIT],
                                     link.sfr_wdata[irq_pkg::EXT0_EDGE_BIT]};
                end
                default: ;
            endcase
        end
    end

    // enable stays effective until the next instruction boundary
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            enable_grace_reg <= 1'b0;
        end else if (link.sfr_wr && link.sfr_addr == irq_pkg::SFR_PRIMARY_ENABLE
                     && primary_enable_reg[irq_pkg::GLOBAL_EN_BIT]
                     && !link.sfr_wdata[irq_pkg::GLOBAL_EN_BIT]) begin
            enable_grace_reg <= 1'b1;
        end else if (link.instr_done || link.take) begin
            enable_grace_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    // global gate; grace only covers a single-cycle successor
    assign global_gate = primary_enable_reg[irq_pkg::GLOBAL_EN_BIT]
                         || (enable_grace_reg && !link.next_multi);
    assign eligible = pending_reg & enable_vec & {NUM_SRC{global_gate}};
    assign cand_high = eligible & priority_vec;
    assign cand_low = eligible & ~priority_vec;

    // high level first, then lowest source number
    always_comb begin
        win_valid = 1'b0;
        win_high = 1'b0;
        win_id = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (cand_low[i]) begin
                win_valid = 1'b1;
                win_id = irq_pkg::ID_W'(i);
            end
        end
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (cand_high[i]) begin
                win_valid = 1'b1;
                win_high = 1'b1;
                win_id = irq_pkg::ID_W'(i);
            end
        end
    end

    // request sampled and decoded every clock, one clock to detect
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_req_reg <= 1'b0;
            irq_id_reg <= '0;
            irq_vector_reg <= 16'h0000;
        end else begin
            // high only over low, never over high; not right after return
            irq_req_reg <= win_valid && !link.take && !ret_hold_reg && !link.reti
                           && !in_high_reg && (win_high || !in_low_reg);
            irq_id_reg <= win_id;
            irq_vector_reg <= irq_pkg::VECTOR_BASE
                              + 16'(win_id) * 16'(irq_pkg::VECTOR_STEP);
        end
    end

    // ---------------------------------------------------------------
    // in-service tracking
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            in_high_reg <= 1'b0;
            in_low_reg <= 1'b0;
        end else if (link.take) begin
            if (priority_vec[link.take_id]) begin
                in_high_reg <= 1'b1;
            end else begin
                in_low_reg <= 1'b1;
            end
        end else if (link.reti) begin
            if (in_high_reg) begin
                in_high_reg <= 1'b0;
            end else begin
                in_low_reg <= 1'b0;
            end
        end
    end

    // one instruction runs after a return before re-vectoring
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ret_hold_reg <= 1'b0;
        end else if (link.reti) begin
            ret_hold_reg <= 1'b1;
        end else if (link.instr_done) begin
            ret_hold_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // read-back and outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sfr_rdata_reg <= 8'h00;
        end else begin
            case (link.sfr_addr)
                irq_pkg::SFR_PRIMARY_ENABLE: sfr_rdata_reg <= primary_enable_reg;
                irq_pkg::SFR_EXTENDED_ENABLE: sfr_rdata_reg <= extended_enable_reg;
                irq_pkg::SFR_PRIMARY_PRIORITY: sfr_rdata_reg <= primary_priority_reg;
                irq_pkg::SFR_EXTENDED_PRIORITY: sfr_rdata_reg <= extended_priority_reg;
                irq_pkg::SFR_PENDING_LO: sfr_rdata_reg <= pending_reg[7:0];
                irq_pkg::SFR_PENDING_HI: sfr_rdata_reg <= {4'h0, pending_reg[11:8]};
                irq_pkg::SFR_EXT_PIN_CONFIG: sfr_rdata_reg <= ext_irq_pin_config_reg;
                irq_pkg::SFR_TIMER_CONTROL: begin
                    sfr_rdata_reg <= {4'h0, pending_reg[irq_pkg::EXT1_SRC], edge_sel_reg[1],
                                      pending_reg[irq_pkg::EXT0_SRC], edge_sel_reg[0]};
                end
                default: sfr_rdata_reg <= 8'h00;
            endcase
        end
    end

    assign link.irq_req = irq_req_reg;
    assign link.irq_id = irq_id_reg;
    assign link.irq_vector = irq_vector_reg;
    assign link.sfr_rdata = sfr_rdata_reg;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            in_service_high_out <= 1'b0;
            in_service_low_out <= 1'b0;
        end else begin
            in_service_high_out <= in_high_reg;
            in_service_low_out <= in_low_reg;
        end
    end
endmodule

// ### core/irq_pkg.sv
// constants shared by the interrupt handler and the core-side port
package irq_pkg;
    localparam int NUM_SRC = 12;
    localparam int ID_W = 4;

    // handler register index space, reached over the link
    localparam logic [2:0] SFR_PRIMARY_ENABLE = 3'h0;
    localparam logic [2:0] SFR_EXTENDED_ENABLE = 3'h1;
    localparam logic [2:0] SFR_PRIMARY_PRIORITY = 3'h2;
    localparam logic [2:0] SFR_EXTENDED_PRIORITY = 3'h3;
    localparam logic [2:0] SFR_PENDING_LO = 3'h4;
    localparam logic [2:0] SFR_PENDING_HI = 3'h5;
    localparam logic [2:0] SFR_EXT_PIN_CONFIG = 3'h6;
    localparam logic [2:0] SFR_TIMER_CONTROL = 3'h7;
    localparam logic [7:0] SFR_RESET = 8'h00;

    // field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int EXT0_EDGE_BIT = 0;
    localparam int EXT0_FLAG_BIT = 1;
    localparam int EXT1_EDGE_BIT = 2;
    localparam int EXT1_FLAG_BIT = 3;
    localparam int EXT0_POL_BIT = 3;
    localparam int EXT1_POL_BIT = 7;

    // source numbering equals arbitration rank, 0 wins
    localparam int EXT0_SRC = 0;
    localparam int EXT1_SRC = 2;
    // sources whose flag is always cleared on vectoring (timer overflows)
    localparam logic [11:0] HW_CLEAR_MASK = 12'h00A;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam int VECTOR_STEP = 8;
    localparam int CALL_CYCLES = 4;

    // apb byte offsets of the core-side port
    localparam logic [11:0] APB_SFR_CMD = 12'h000;
    localparam logic [11:0] APB_SFR_DATA = 12'h004;
    localparam logic [11:0] APB_STATUS = 12'h008;
    localparam int CMD_WRITE_BIT = 31;
    localparam int STATUS_CALL_BIT = 16;
    localparam int STATUS_REQ_BIT = 17;
endpackage

// ### core/irq_link_if.sv
// link between the interrupt handler and the processor core port
`timescale 1ns/10ps
interface irq_link_if;
    // handler to core
    logic irq_req;
    logic [irq_pkg::ID_W-1:0] irq_id;
    logic [15:0] irq_vector;
    logic [7:0] sfr_rdata;
    // core to handler
    logic take;
    logic [irq_pkg::ID_W-1:0] take_id;
    logic reti;
    logic instr_done;
    logic next_multi;
    logic sfr_wr;
    logic [2:0] sfr_addr;
    logic [7:0] sfr_wdata;

    modport handler (
        output irq_req, irq_id, irq_vector, sfr_rdata,
        input take, take_id, reti, instr_done, next_multi, sfr_wr, sfr_addr, sfr_wdata
    );
    modport core (
        input irq_req, irq_id, irq_vector, sfr_rdata,
        output take, take_id, reti, instr_done, next_multi, sfr_wr, sfr_addr, sfr_wdata
    );
endinterface

// ### core/cpu_irq_port.sv
// core-side end: instruction boundary vectoring, call sequence, apb access to handler
`timescale 1ns/10ps
module cpu_irq_port (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // core pipeline
    input wire logic cpu_instr_done_in,
    input wire logic cpu_next_multi_in,
    input wire logic cpu_reti_in,
    output logic cpu_call_out,
    output logic [15:0] cpu_vector_out,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [31:0] prdata_out,
    // link to the handler
    irq_link_if.core link
);
    typedef enum {RUN, CALL} call_state_type;

    call_state_type state_reg;
    logic [2:0] call_cnt_reg;
    logic take_reg;
    logic [irq_pkg::ID_W-1:0] take_id_reg;
    logic reti_reg;
    logic instr_done_reg;
    logic next_multi_reg;
    logic sfr_wr_reg;
    logic [2:0] sfr_addr_reg;
    logic [7:0] sfr_wdata_reg;
    logic [15:0] vector_reg;
    logic access;

    // ---------------------------------------------------------------
    // vectoring
    // ---------------------------------------------------------------
    // vector only at an instruction boundary, then a four-clock call
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg <= RUN;
            call_cnt_reg <= 3'h0;
            take_reg <= 1'b0;
            take_id_reg <= '0;
            vector_reg <= 16'h0000;
            cpu_call_out <= 1'b0;
        end else begin
            take_reg <= 1'b0;
            cpu_call_out <= 1'b0;
            case (state_reg)
                RUN: begin
                    if (link.irq_req && cpu_instr_done_in) begin
                        take_reg <= 1'b1;
                        take_id_reg <= link.irq_id;
                        vector_reg <= link.irq_vector;
                        call_cnt_reg <= 3'(irq_pkg::CALL_CYCLES - 1);
                        state_reg <= CALL;
                    end
                end
                CALL: begin
                    // call completes on the fourth clock
                    if (call_cnt_reg == 3'h1) begin
                        cpu_call_out <= 1'b1;
                        state_reg <= RUN;
                    end
                    call_cnt_reg <= call_cnt_reg - 3'h1;
                end
                default: state_reg <= RUN;
            endcase
        end
    end

    // return and boundary events forwarded to the handler
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            reti_reg <= 1'b0;
            instr_done_reg <= 1'b0;
            next_multi_reg <= 1'b0;
        end else begin
            reti_reg <= cpu_reti_in;
            instr_done_reg <= cpu_instr_done_in && state_reg == RUN;
            // software keeps a two-byte opcode after an enable clear
            next_multi_reg <= cpu_next_multi_in;
        end
    end

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    // one wait state per access; handler read data settles in that cycle
    assign access = psel_in && penable_in && !pready_out;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            sfr_wr_reg <= 1'b0;
            sfr_addr_reg <= 3'h0;
            sfr_wdata_reg <= 8'h00;
        end else begin
            pready_out <= access;
            pslverr_out <= 1'b0;
            sfr_wr_reg <= 1'b0;
            if (access) begin
                case (paddr_in)
                    irq_pkg::APB_SFR_CMD: begin
                        if (pwrite_in) begin
                            sfr_addr_reg <= pwdata_in[10:8];
                            sfr_wdata_reg <= pwdata_in[7:0];
                            sfr_wr_reg <= pwdata_in[irq_pkg::CMD_WRITE_BIT];
                        end
                        prdata_out <= {21'h000000, sfr_addr_reg, sfr_wdata_reg};
                    end
                    irq_pkg::APB_SFR_DATA: prdata_out <= {24'h000000, link.sfr_rdata};
                    irq_pkg::APB_STATUS: begin
                        prdata_out <= {14'h0000, link.irq_req, state_reg == CALL, vector_reg};
                    end
                    default: begin
                        pslverr_out <= 1'b1;
                        prdata_out <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign link.take = take_reg;
    assign link.take_id = take_id_reg;
    assign link.reti = reti_reg;
    assign link.instr_done = instr_done_reg;
    assign link.next_multi = next_multi_reg;
    assign link.sfr_wr = sfr_wr_reg;
    assign link.sfr_addr = sfr_addr_reg;
    assign link.sfr_wdata = sfr_wdata_reg;
    assign cpu_vector_out = vector_reg;
endmodule

// ### bench/irq_link_assertions.sv
// link-level assertions for the handler and core port
`timescale 1ns/10ps
module irq_link_assertions (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // link signals
    input wire logic irq_req,
    input wire logic [irq_pkg::ID_W-1:0] irq_id,
    input wire logic [15:0] irq_vector,
    input wire logic take,
    input wire logic [irq_pkg::ID_W-1:0] take_id,
    input wire logic reti
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // the call sequence occupies the core end, so no second take can start inside it
    sequence call_busy_s;
        !take [*3];
    endsequence
    take_gap_a: assert property (take |=> call_busy_s)
        else $error("take repeated inside call");
    take_cause_a: assert property (take |-> $past(irq_req))
        else $error("take without request");
    take_pair_a: assert property (take |-> take_id == $past(irq_id))
        else $error("take id differs from request id");
    id_range_a: assert property (irq_req |-> irq_id < 4'hC)
        else $error("request id out of range");
    vector_map_a: assert property (irq_req |-> irq_vector == 16'h0003 + {irq_id, 3'b000})
        else $error("vector does not match id");
    reti_hold_a: assert property (reti |=> !take [*2])
        else $error("take right after return");
    fresh_req_a: assert property ($rose(irq_req) |-> !take)
        else $error("take in detect cycle");
    take_drop_a: assert property (take |-> !$past(take))
        else $error("take longer than one cycle");
endmodule

// ### bench/tb.sv
// bench: handler and core port joined by the link, driven over apb
`timescale 1ns/10ps
module tb;
    logic clk_in, reset_in, done, reti, psel, penable, pwrite, pready, perr, err, call, hi, lo;
    logic ext0, multi;
    logic [11:0] ev, paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] vec;
    int error_cnt, compares;
    irq_link_if link();
    two_level_interrupt_handler two_level_interrupt_handler_inst (.clk_in(clk_in),
        .reset_in(reset_in), .src_event_in(ev), .ext_irq0_input_in(ext0),
        .ext_irq1_input_in(1'b1), .in_service_high_out(hi), .in_service_low_out(lo), .link(link));
    cpu_irq_port cpu_irq_port_inst (.clk_in(clk_in), .reset_in(reset_in),
        .cpu_instr_done_in(done), .cpu_next_multi_in(multi), .cpu_reti_in(reti),
        .cpu_call_out(call), .cpu_vector_out(vec), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .pslverr_out(perr), .prdata_out(prdata), .link(link));
    irq_link_assertions irq_link_assertions_inst (.clk_in(clk_in), .reset_in(reset_in),
        .irq_req(link.irq_req), .irq_id(link.irq_id), .irq_vector(link.irq_vector),
        .take(link.take), .take_id(link.take_id), .reti(link.reti));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic final_report();
        $display("mismatches %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) check("pready", 32'h1, 32'h0);
        if (pready !== 1'b1) final_report();
        @(posedge clk_in);
    endtask
    task automatic hw(input logic [2:0] i, input logic [7:0] d);
        apb(1'b1, 12'h000, {1'b1, 20'h00000, i, d});
    endtask
    task automatic hr(input logic [2:0] i, input logic [7:0] exp);
        apb(1'b1, 12'h000, {21'h000000, i, 8'h00});
        apb(1'b0, 12'h004, 32'h00000000);
        check("sfr", {24'h000000, exp}, rd);
    endtask
    // no-call cases still pulse a boundary so a wrongly open gate would vector
    task automatic serve(input logic want, input logic [15:0] exp);
        int n;
        logic seen;
        repeat (3) @(posedge clk_in);
        done <= 1'b1;
        @(posedge clk_in);
        done <= 1'b0;
        seen = 1'b0;
        for (n = 0; n < 12 && !seen; n++) begin
            @(posedge clk_in);
            seen = (call === 1'b1);
        end
        check("call", {31'h0, want}, {31'h0, seen});
        if (want) check("vector", {16'h0000, exp}, {16'h0000, vec});
        if (want && !seen) final_report();
    endtask
    task automatic ret();
        reti <= 1'b1;
        @(posedge clk_in);
        reti <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    initial begin
        {done, reti, multi, psel, penable, pwrite, ev, paddr, pwdata} = '0;
        ext0 = 1'b1;
        reset_in = 1'b1;
        error_cnt = 0;
        compares = 0;
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        hr(3'h0, 8'h00);
        hr(3'h2, 8'h00);
        ev <= 12'h020;
        @(posedge clk_in);
        ev <= 12'h000;
        hr(3'h4, 8'h20);
        hw(3'h0, 8'h20);
        serve(1'b0, 16'h0000);
        hw(3'h0, 8'hA0);
        multi <= 1'b1;
        hw(3'h0, 8'h20);
        serve(1'b0, 16'h0000);
        multi <= 1'b0;
        hw(3'h0, 8'hA0);
        serve(1'b1, 16'h002B);
        hr(3'h4, 8'h20);
        check("low", 32'h1, {31'h0, lo});
        serve(1'b0, 16'h0000);
        hw(3'h2, 8'h02);
        hw(3'h0, 8'hA2);
        hw(3'h4, 8'h22);
        serve(1'b1, 16'h000B);
        check("high", 32'h1, {31'h0, hi});
        hr(3'h4, 8'h20);
        ret();
        hw(3'h4, 8'h00);
        ret();
        check("low", 32'h0, {31'h0, lo});
        hw(3'h0, 8'hB0);
        hw(3'h4, 8'h30);
        serve(1'b0, 16'h0000);
        serve(1'b1, 16'h0023);
        ret();
        serve(1'b0, 16'h0000);
        serve(1'b1, 16'h0023);
        apb(1'b0, 12'h008, 32'h00000000);
        check("status", 32'h00000023, rd);
        ext0 <= 1'b0;
        hr(3'h7, 8'h02);
        ext0 <= 1'b1;
        hr(3'h7, 8'h00);
        apb(1'b0, 12'h00C, 32'h00000000);
        check("slverr", 32'h1, {31'h0, err});
        hw(3'h2, 8'h01);
        hw(3'h0, 8'hB1);
        hw(3'h7, 8'h01);
        ext0 <= 1'b0;
        serve(1'b1, 16'h0003);
        hr(3'h7, 8'h01);
        ext0 <= 1'b1;
        final_report();
    end
endmodule
